// >>> src/psc_clk_div.sv
`timescale 1ns/1ps
module psc_clk_div (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [1:0] div_sel_i,
    input wire logic run_i,
    output logic pb_edge_o
);

    logic [2:0] cnt;
    logic [2:0] limit;

    // ---------------------------------------------------------------
    // ratio decode
    // ---------------------------------------------------------------
    always_comb begin
        case (div_sel_i)
            psc_pkg::DIV_1: limit = 3'h0;
            psc_pkg::DIV_2: limit = 3'h1;
            psc_pkg::DIV_4: limit = 3'h3;
            psc_pkg::DIV_8: limit = 3'h7;
            default: limit = 3'h0;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 3'h0;
        end else if (!run_i || cnt >= limit) begin
            cnt <= 3'h0;
        end else begin
            cnt <= cnt + 3'h1;
        end
    end

    assign pb_edge_o = run_i && (cnt >= limit);

endmodule : psc_clk_div

// >>> src/psc_pkg.sv
package psc_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] OSC_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] PERIPH_IDLE_OFFSET = 8'h04;
    localparam logic [7:0] PWR_STATUS_OFFSET = 8'h08;
    localparam logic [7:0] CLK_SWITCH_OFFSET = 8'h0c;

    localparam int SLEEP_SELECT_BIT = 4;
    localparam int DIV_LSB = 19;
    localparam int DIV_MSB = 20;
    localparam logic [31:0] OSC_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] PERIPH_IDLE_RESET = 32'h0000_0000;
    localparam int NUM_PERIPH = 8;
    localparam int PRIO_W = 3;

    // ---------------------------------------------------------------
    // divisor encodings
    // ---------------------------------------------------------------
    localparam logic [1:0] DIV_1 = 2'h0;
    localparam logic [1:0] DIV_2 = 2'h1;
    localparam logic [1:0] DIV_4 = 2'h2;
    localparam logic [1:0] DIV_8 = 2'h3;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int OSC_START_US = 1000;
    localparam int PLL_LOCK_US = 2000;
    localparam int OSC_START_CYC = (OSC_START_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PSC_RUN,
        PSC_IDLE,
        PSC_SLEEP
    } psc_mode_t;

    typedef struct packed {
        logic valid;
        logic [PRIO_W-1:0] prio;
    } psc_irq_t;

endpackage : psc_pkg

// >>> src/psc_power_ctrl.sv
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// RL1: sleep wakes on higher-priority enabled interrupt
// RL2: any reset ends sleep
// RL3: watchdog time-out wakes from sleep
// RL4: low-priority interrupt in sleep moves to idle
// RL5: idle halts processor, system clock runs
// RL6: stop_in_idle bit stops peripheral in idle
// RL7: wait with sleep_select clear enters idle
// RL8: idle wakes on higher-priority interrupt, not on lower or equal
// RL9: any reset ends idle
// RL10: watchdog time-out wakes from idle
// RL11: peripheral clock is system clock /1,/2,/4,/8
// RL12: core-side users keep undivided system clock
// RL13: peripheral read completes at next peripheral edge
// RL14: disabled crystal/pll source waits start-up and lock
// RL15: leaving idle adds no start-up delay
// RL16: no debug freeze behaviour
// RL17: divisor codes 00,01,10,11 give 1,2,4,8
// RL18: wait with sleep_select set enters sleep
module psc_power_ctrl #(
    parameter int OSC_START_CYCLES = psc_pkg::OSC_START_CYC,
    parameter int PLL_LOCK_CYCLES = psc_pkg::PLL_LOCK_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wait_exec_i,
    input wire psc_pkg::psc_irq_t irq_i,
    input wire logic irq_sleep_capable_i,
    input wire logic [psc_pkg::PRIO_W-1:0] cpu_prio_i,
    input wire logic wdt_timeout_i,
    input wire logic debug_halt_i,
    input wire logic periph_rd_req_i,
    output logic periph_rd_done_o,
    output logic cpu_halt_o,
    output logic cpu_wake_o,
    output logic sys_clk_en_o,
    output logic pb_clk_en_o,
    output logic [psc_pkg::NUM_PERIPH-1:0] periph_run_o,
    output logic src_ready_o
);

    psc_pkg::psc_mode_t mode;
    psc_pkg::psc_mode_t next_mode;
    logic [31:0] osc_ctrl;
    logic [psc_pkg::NUM_PERIPH-1:0] stop_in_idle;
    logic pb_edge;
    logic rd_pending;
    logic [31:0] src_cnt;
    logic wake_irq;
    logic low_irq;
    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : apply_strb

    // ---------------------------------------------------------------
    // wake decode
    // ---------------------------------------------------------------
    // debug_halt_i deliberately unused: no freeze path [RL16]
    assign wake_irq = irq_i.valid && (irq_i.prio > cpu_prio_i); // [RL1] [RL8]
    assign low_irq = irq_i.valid && !(irq_i.prio > cpu_prio_i);

    // ---------------------------------------------------------------
    // mode state machine
    // ---------------------------------------------------------------
    always_comb begin
        next_mode = mode;
        case (mode)
            psc_pkg::PSC_RUN: begin
                if (wait_exec_i) begin
                    if (osc_ctrl[psc_pkg::SLEEP_SELECT_BIT]) begin
                        next_mode = psc_pkg::PSC_SLEEP; // [RL18]
                    end else begin
                        next_mode = psc_pkg::PSC_IDLE; // [RL7]
                    end
                end
            end
            psc_pkg::PSC_IDLE: begin
                if (wdt_timeout_i || wake_irq) begin
                    next_mode = psc_pkg::PSC_RUN; // [RL8] [RL10] [RL15]
                end
            end
            psc_pkg::PSC_SLEEP: begin
                if (wdt_timeout_i || (wake_irq && irq_sleep_capable_i)) begin
                    next_mode = psc_pkg::PSC_RUN; // [RL1] [RL3]
                end else if (low_irq && irq_sleep_capable_i) begin
                    next_mode = psc_pkg::PSC_IDLE; // [RL4]
                end
            end
            default: next_mode = psc_pkg::PSC_RUN;
        endcase
    end

    // any reset returns to run through the reset path
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode <= psc_pkg::PSC_RUN; // [RL2] [RL9]
        end else begin
            mode <= next_mode;
        end
    end

    // ---------------------------------------------------------------
    // clock gating outputs
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cpu_halt_o <= 1'b0;
            cpu_wake_o <= 1'b0;
            sys_clk_en_o <= 1'b1;
            pb_clk_en_o <= 1'b1;
        end else begin
            cpu_halt_o <= (next_mode != psc_pkg::PSC_RUN); // [RL5]
            cpu_wake_o <= (mode != psc_pkg::PSC_RUN) && (next_mode == psc_pkg::PSC_RUN);
            sys_clk_en_o <= (next_mode != psc_pkg::PSC_SLEEP); // [RL5] [RL12]
            pb_clk_en_o <= (next_mode != psc_pkg::PSC_SLEEP); // [RL4] [RL18]
        end
    end

    generate
        for (genvar g = 0; g < psc_pkg::NUM_PERIPH; g++) begin : g_periph
            always_ff @(posedge core_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    periph_run_o[g] <= 1'b1;
                end else begin
                    periph_run_o[g] <= (next_mode == psc_pkg::PSC_RUN) ||
                        (next_mode == psc_pkg::PSC_IDLE && !stop_in_idle[g]); // [RL6]
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // peripheral clock divider and read stretch
    // ---------------------------------------------------------------
    psc_clk_div u_div (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .div_sel_i(osc_ctrl[psc_pkg::DIV_MSB:psc_pkg::DIV_LSB]), // [RL11] [RL17]
        .run_i(mode != psc_pkg::PSC_SLEEP),
        .pb_edge_o(pb_edge)
    );

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_pending <= 1'b0;
            periph_rd_done_o <= 1'b0;
        end else begin
            periph_rd_done_o <= 1'b0;
            if ((rd_pending || periph_rd_req_i) && pb_edge) begin
                rd_pending <= 1'b0;
                periph_rd_done_o <= 1'b1; // [RL13]
            end else if (periph_rd_req_i) begin
                rd_pending <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // clock source switch delay
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            src_cnt <= 32'h0;
            src_ready_o <= 1'b1;
        end else if (do_write && aw_addr == psc_pkg::CLK_SWITCH_OFFSET && w_data[0]) begin
            src_cnt <= 32'(OSC_START_CYCLES) + (w_data[1] ? 32'(PLL_LOCK_CYCLES) : 32'h0); // [RL14]
            src_ready_o <= 1'b0;
        end else if (src_cnt > 32'h1) begin
            src_cnt <= src_cnt - 32'h1;
        end else begin
            src_cnt <= 32'h0;
            src_ready_o <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // axi4-lite write
    // ---------------------------------------------------------------
    assign do_write = aw_hold && w_hold && !s_axi_bvalid;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= psc_pkg::AXI_OKAY;
        end else begin
            s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == psc_pkg::OSC_CTRL_OFFSET ||
                                aw_addr == psc_pkg::PERIPH_IDLE_OFFSET ||
                                aw_addr == psc_pkg::CLK_SWITCH_OFFSET) ?
                               psc_pkg::AXI_OKAY : psc_pkg::AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            osc_ctrl <= psc_pkg::OSC_CTRL_RESET;
            stop_in_idle <= psc_pkg::NUM_PERIPH'(psc_pkg::PERIPH_IDLE_RESET);
        end else if (do_write) begin
            if (aw_addr == psc_pkg::OSC_CTRL_OFFSET) begin
                osc_ctrl <= apply_strb(osc_ctrl, w_data, w_strb);
            end
            if (aw_addr == psc_pkg::PERIPH_IDLE_OFFSET) begin
                stop_in_idle <= psc_pkg::NUM_PERIPH'(
                    apply_strb(32'(stop_in_idle), w_data, w_strb));
            end
        end
    end

    // ---------------------------------------------------------------
    // axi4-lite read
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= psc_pkg::AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= psc_pkg::AXI_OKAY;
                case (s_axi_araddr)
                    psc_pkg::OSC_CTRL_OFFSET: s_axi_rdata <= osc_ctrl;
                    psc_pkg::PERIPH_IDLE_OFFSET: s_axi_rdata <= 32'(stop_in_idle);
                    psc_pkg::PWR_STATUS_OFFSET: s_axi_rdata <= {29'h0, src_ready_o, 2'(mode)};
                    psc_pkg::CLK_SWITCH_OFFSET: s_axi_rdata <= 32'h0;
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= psc_pkg::AXI_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_SLEEP_WAKE: assert property (mode == psc_pkg::PSC_SLEEP && wake_irq && // [RL1]
        irq_sleep_capable_i |=> mode == psc_pkg::PSC_RUN) else $error("no wake");
    AST_WDT_SLEEP: assert property (mode == psc_pkg::PSC_SLEEP && wdt_timeout_i // [RL3]
        |=> mode == psc_pkg::PSC_RUN) else $error("wdt no wake");
    AST_LOW_IDLE: assert property (mode == psc_pkg::PSC_SLEEP && !wdt_timeout_i && // [RL4]
        low_irq && irq_sleep_capable_i |=> mode == psc_pkg::PSC_IDLE && pb_clk_en_o)
        else $error("no idle");
    AST_IDLE_HALT: assert property (mode == psc_pkg::PSC_IDLE |-> // [RL5]
        cpu_halt_o && sys_clk_en_o) else $error("idle clocks");
    AST_ENTER_IDLE: assert property (mode == psc_pkg::PSC_RUN && wait_exec_i && // [RL7]
        !osc_ctrl[psc_pkg::SLEEP_SELECT_BIT] |=> mode == psc_pkg::PSC_IDLE)
        else $error("no idle entry");
    AST_IDLE_STAY: assert property (mode == psc_pkg::PSC_IDLE && !wdt_timeout_i && // [RL8]
        !wake_irq |=> mode == psc_pkg::PSC_IDLE) else $error("idle left");
    AST_WDT_IDLE: assert property (mode == psc_pkg::PSC_IDLE && wdt_timeout_i // [RL10] [RL15]
        |=> mode == psc_pkg::PSC_RUN && !cpu_halt_o) else $error("idle wdt");
    AST_RD_DONE: assert property (periph_rd_req_i && !rd_pending && // [RL13]
        mode == psc_pkg::PSC_RUN |-> ##[1:8] periph_rd_done_o)
        else $error("read stuck");
    AST_ENTER_SLEEP: assert property (mode == psc_pkg::PSC_RUN && wait_exec_i && // [RL18]
        osc_ctrl[psc_pkg::SLEEP_SELECT_BIT] |=> mode == psc_pkg::PSC_SLEEP ##0 !pb_clk_en_o)
        else $error("no sleep");
    AST_SLEEP_CLOCKS: assert property (mode == psc_pkg::PSC_SLEEP |-> // [RL18]
        !sys_clk_en_o && !pb_clk_en_o && periph_run_o == '0) else $error("sleep clocks");
    AST_IDLE_PERIPH: assert property (mode == psc_pkg::PSC_RUN && // [RL6]
        next_mode == psc_pkg::PSC_IDLE |=> periph_run_o == ~$past(stop_in_idle))
        else $error("idle periph run");
    AST_WAKE_PULSE: assert property (mode != psc_pkg::PSC_RUN && // [RL1] [RL3] [RL10]
        next_mode == psc_pkg::PSC_RUN |=> cpu_wake_o ##1 !cpu_wake_o)
        else $error("wake pulse");

    COV_SLEEP: cover property (mode == psc_pkg::PSC_SLEEP ##1 mode == psc_pkg::PSC_RUN);
    COV_IDLE: cover property (mode == psc_pkg::PSC_IDLE ##1 mode == psc_pkg::PSC_RUN);
    COV_S2I: cover property (mode == psc_pkg::PSC_SLEEP ##1 mode == psc_pkg::PSC_IDLE);
    COV_RD: cover property (periph_rd_done_o);
    COV_RD_DIV8: cover property (periph_rd_done_o &&
        osc_ctrl[psc_pkg::DIV_MSB:psc_pkg::DIV_LSB] == psc_pkg::DIV_8);

endmodule : psc_power_ctrl

// >>> testbench/power_save_and_periph_clock_ctrl_tb.sv
`timescale 1ns/1ps
module power_save_and_periph_clock_ctrl_tb;
    typedef struct packed {
        logic slp; logic ival; logic [2:0] prio; logic cap; logic wdt; logic [1:0] mode;
    } psc_row_t;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic clk;
    logic rst_b;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    psc_pkg::psc_irq_t irq = '0;
    logic cap = 1'b0, wdt = 1'b0, dbg = 1'b0, do_wait = 1'b0, do_rd = 1'b0;
    logic [2:0] cpu_prio = 3'h3;
    logic wait_exec, rd_req, rd_done, halt, wake, sys_en, pb_en, src_rdy, rd_busy;
    logic [7:0] prun, rd_lat;
    int errors = 0, cmp_count = 0, lo_cnt = 0, wake_cnt = 0;
    logic [7:0] max_lat [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
    psc_row_t rows [7] = '{
        '{1'b0, 1'b1, 3'h5, 1'b0, 1'b0, psc_pkg::PSC_RUN},
        '{1'b0, 1'b1, 3'h3, 1'b0, 1'b0, psc_pkg::PSC_IDLE},
        '{1'b1, 1'b1, 3'h5, 1'b1, 1'b0, psc_pkg::PSC_RUN},
        '{1'b1, 1'b1, 3'h2, 1'b1, 1'b0, psc_pkg::PSC_IDLE},
        '{1'b1, 1'b1, 3'h5, 1'b0, 1'b0, psc_pkg::PSC_SLEEP},
        '{1'b1, 1'b0, 3'h0, 1'b0, 1'b1, psc_pkg::PSC_RUN},
        '{1'b0, 1'b0, 3'h0, 1'b0, 1'b1, psc_pkg::PSC_RUN}};

    psc_power_ctrl #(.OSC_START_CYCLES(4), .PLL_LOCK_CYCLES(4)) i_dut (
        .core_clk_i(clk), .rst_b_i(rst_b),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wait_exec_i(wait_exec),
        .irq_i(irq), .irq_sleep_capable_i(cap), .cpu_prio_i(cpu_prio),
        .wdt_timeout_i(wdt), .debug_halt_i(dbg), .periph_rd_req_i(rd_req),
        .periph_rd_done_o(rd_done), .cpu_halt_o(halt), .cpu_wake_o(wake),
        .sys_clk_en_o(sys_en), .pb_clk_en_o(pb_en), .periph_run_o(prun),
        .src_ready_o(src_rdy));

    psc_core_model i_core (
        .core_clk_i(clk), .rst_b_i(rst_b), .do_wait_i(do_wait), .do_rd_i(do_rd),
        .rd_done_i(rd_done), .wait_exec_o(wait_exec), .rd_req_o(rd_req),
        .rd_busy_o(rd_busy), .rd_lat_o(rd_lat));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (src_rdy === 1'b0) lo_cnt <= lo_cnt + 1;
        if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bready && bvalid === 1'b1) begin
                bready <= 1'b0;
                r = bresp;
            end
        end while ((awvalid || wvalid || bready) && n < 50);
        chk("axi_wr_done", 0, (n >= 50));
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rready && rvalid === 1'b1) begin
                rready <= 1'b0;
                d = rdata;
                r = rresp;
            end
        end while ((arvalid || rready) && n < 50);
        chk("axi_rd_done", 0, (n >= 50));
    endtask : axi_rd

    task automatic chk_mode(input logic [1:0] m);
        axi_rd(psc_pkg::PWR_STATUS_OFFSET, rd, rsp);
        chk("status_mode", {30'h0, m}, {30'h0, rd[1:0]});
    endtask : chk_mode

    task automatic pulse_wait;
        @(posedge clk);
        do_wait <= 1'b1;
        @(posedge clk);
        do_wait <= 1'b0;
        tick(4);
    endtask : pulse_wait

    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        tick(20000);
        errors++;
        $display("Error watchdog expected done seen timeout");
        report_and_stop();
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        tick(3);
        rst_b <= 1'b1;
        axi_rd(psc_pkg::OSC_CTRL_OFFSET, rd, rsp);
        chk("osc_ctrl_reset", psc_pkg::OSC_CTRL_RESET, rd);
        axi_rd(psc_pkg::PERIPH_IDLE_OFFSET, rd, rsp);
        chk("idle_mask_reset", psc_pkg::PERIPH_IDLE_RESET, rd);
        axi_rd(8'h10, rd, rsp);
        chk("unmapped_rresp", {30'h0, psc_pkg::AXI_SLVERR}, {30'h0, rsp});
        chk("unmapped_rdata", 32'h0, rd);
        axi_wr(8'h10, 32'hffff_ffff, rsp);
        chk("unmapped_bresp", {30'h0, psc_pkg::AXI_SLVERR}, {30'h0, rsp});
        axi_wr(psc_pkg::PERIPH_IDLE_OFFSET, 32'h0000_00a5, rsp);
        chk("idle_mask_bresp", {30'h0, psc_pkg::AXI_OKAY}, {30'h0, rsp});
        for (int c = 0; c < 4; c++) begin
            axi_wr(psc_pkg::OSC_CTRL_OFFSET, 32'(c) << psc_pkg::DIV_LSB, rsp);
            for (int g = 0; g < 8; g++) begin
                tick(g);
                @(posedge clk);
                do_rd <= 1'b1;
                @(posedge clk);
                do_rd <= 1'b0;
                tick(2);
                for (int n = 0; n < 20 && rd_busy !== 1'b0; n++) @(posedge clk);
                chk("rd_lat_ok", 1, (rd_lat >= 8'h01 && rd_lat <= max_lat[c]));
            end
        end
        dbg <= 1'b1;
        foreach (rows[i]) begin
            axi_wr(psc_pkg::OSC_CTRL_OFFSET, 32'(rows[i].slp) << psc_pkg::SLEEP_SELECT_BIT, rsp);
            pulse_wait();
            chk("halt_entry", 1, halt);
            chk("sys_clk_entry", !rows[i].slp, sys_en);
            chk("pb_clk_entry", !rows[i].slp, pb_en);
            chk("periph_run_entry", rows[i].slp ? 8'h00 : 8'h5a, prun);
            chk_mode(rows[i].slp ? psc_pkg::PSC_SLEEP : psc_pkg::PSC_IDLE);
            wake_cnt = 0;
            irq <= {rows[i].ival, rows[i].prio};
            cap <= rows[i].cap;
            wdt <= rows[i].wdt;
            @(posedge clk);
            wdt <= 1'b0;
            tick(4);
            chk_mode(rows[i].mode);
            chk("wake_pulse", rows[i].mode == psc_pkg::PSC_RUN, wake_cnt);
            chk("halt_event", rows[i].mode != psc_pkg::PSC_RUN, halt);
            chk("pb_clk_event", rows[i].mode != psc_pkg::PSC_SLEEP, pb_en);
            chk("src_ready_wake", 1, src_rdy);
            irq <= '0;
            wdt <= 1'b1;
            @(posedge clk);
            wdt <= 1'b0;
            tick(4);
        end
        for (int s = 0; s < 2; s++) begin
            lo_cnt = 0;
            axi_wr(psc_pkg::CLK_SWITCH_OFFSET, 32'h1 + 32'(2 * s), rsp);
            tick(40);
            chk("switch_delay", 1, (lo_cnt >= 4 + 4 * s && lo_cnt <= 6 + 4 * s));
            chk("src_ready_end", 1, src_rdy);
        end
        for (int s = 0; s < 2; s++) begin
            axi_wr(psc_pkg::OSC_CTRL_OFFSET, 32'(s) << psc_pkg::SLEEP_SELECT_BIT, rsp);
            pulse_wait();
            rst_b <= 1'b0;
            tick(3);
            rst_b <= 1'b1;
            tick(1);
            chk("halt_reset", 0, halt);
            chk("clk_en_reset", 2'h3, {sys_en, pb_en});
            chk("periph_run_reset", 8'hff, prun);
            chk_mode(psc_pkg::PSC_RUN);
        end
        report_and_stop();
    end
endmodule : power_save_and_periph_clock_ctrl_tb

// >>> testbench/psc_core_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// core side: issues wait and peripheral reads, times each read
// ---------------------------------------------------------------
module psc_core_model (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic do_wait_i,
    input wire logic do_rd_i,
    input wire logic rd_done_i,
    output logic wait_exec_o,
    output logic rd_req_o,
    output logic rd_busy_o,
    output logic [7:0] rd_lat_o
);
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_exec_o <= 1'b0;
            rd_req_o <= 1'b0;
            rd_busy_o <= 1'b0;
            rd_lat_o <= 8'h00;
        end else begin
            wait_exec_o <= do_wait_i;
            rd_req_o <= do_rd_i && !rd_busy_o;
            // cycles from request to completion
            if (rd_req_o) begin
                rd_busy_o <= 1'b1;
                rd_lat_o <= 8'h01;
            end else if (rd_busy_o && rd_done_i) begin
                rd_busy_o <= 1'b0;
            end else if (rd_busy_o) begin
                rd_lat_o <= rd_lat_o + 8'h01;
            end
        end
    end
endmodule : psc_core_model
